//--- rtl/dlcp_deskew_loop.sv
// Delay-locked clock deskew loop, sampled on the reference clock
`timescale 1ns/10ps
module dlcp_deskew_loop
  import dlcp_pkg::*;
#(
  parameter dlcp_variant_t      VARIANT     = DLCP_FULL,
  parameter logic [LOCK_W-1:0]  LOCK_CYCLES = LOCK_CYCLES_DEF
)(
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic source_clock_in_i,
  input  wire logic feedback_clock_in_i,
  input  wire logic loop_rst_i,
  input  wire logic dcc_enable_i,
  output logic      phase0_clock_out_o,
  output logic      doubled_clock_out_o,
  output logic      lock_o
);

  dlcp_wave_if wave ();

  dlcp_state_t       state_reg;
  dlcp_state_t       state_next;
  logic              src_q_reg;
  logic              fb_q_reg;
  logic [CNT_W-1:0]  period_reg;
  logic [CNT_W-1:0]  period_next;
  logic [CNT_W-1:0]  tap_reg;
  logic [CNT_W-1:0]  tap_next;
  logic [CNT_W-1:0]  fb_off_reg;
  logic              fb_seen_reg;
  logic [LOCK_W-1:0] lock_cnt_reg;
  logic [LOCK_W-1:0] lock_cnt_next;
  logic              phase0_reg;
  logic              phase0_next;
  logic              doubled_reg;
  logic              doubled_next;
  logic              lock_reg;
  logic              lock_next;

  // ==========================================================================
  // Variant decode and edge detection
  wire is_simple = (VARIANT == DLCP_SIMPLE);
  wire has_dbl   = (VARIANT != DLCP_HIGH_FREQ);
  wire loop_rst  = !is_simple && loop_rst_i;
  // Simple macro closes the loop internally through the global buffer path
  wire fb_src    = is_simple ? phase0_reg : feedback_clock_in_i;
  wire src_rise  = source_clock_in_i && !src_q_reg;
  wire fb_rise   = fb_src && !fb_q_reg;

  wire [CNT_W-1:0] meas      = wave.cnt + CNT_ONE;
  wire             period_ok = (meas == period_reg);
  wire [CNT_W-1:0] half      = period_reg >> 1;
  wire [CNT_W-1:0] tap_inc   = dlcp_mod_add(tap_reg, CNT_ONE, period_reg);
  wire [CNT_W-1:0] tap_dec   = dlcp_mod_add(tap_reg, period_reg - CNT_ONE, period_reg);
  wire             misalign  = src_rise && period_ok && fb_seen_reg && !fb_rise;

  // ==========================================================================
  // Period tracking and tap steering
  assign period_next = loop_rst ? CNT_ZERO :
                       (src_rise && !period_ok) ? meas : period_reg;

  assign tap_next = loop_rst                 ? CNT_ZERO :
                    (src_rise && !period_ok) ? CNT_ZERO :
                    !misalign                ? tap_reg :
                    (fb_off_reg < half)      ? tap_inc : tap_dec;

  assign lock_cnt_next = loop_rst ? LOCK_ZERO :
                         !src_rise ? lock_cnt_reg :
                         !(period_ok && fb_rise) ? LOCK_ZERO :
                         (lock_cnt_reg >= LOCK_CYCLES) ? lock_cnt_reg : lock_cnt_reg + LOCK_ONE;

  // ==========================================================================
  // Loop state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_LOOP_RESET: begin
        if (!loop_rst) begin
          state_next = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        if (loop_rst) begin
          state_next = ST_LOOP_RESET;
        end else if (lock_cnt_reg >= LOCK_CYCLES) begin
          state_next = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (loop_rst) begin
          state_next = ST_LOOP_RESET;
        end
      end
      default: begin
        state_next = ST_LOOP_RESET;
      end
    endcase
  end

  // ==========================================================================
  // Output selection
  wire in_rst  = (state_next == ST_LOOP_RESET);
  wire locked  = (state_next == ST_LOCKED);

  assign lock_next    = locked && !is_simple;
  assign phase0_next  = in_rst        ? source_clock_in_i :
                        dcc_enable_i  ? wave.ph0_corr :
                        source_clock_in_i;
  assign doubled_next = !has_dbl || is_simple ? 1'b0 :
                        in_rst  ? 1'b0 :
                        locked  ? wave.dbl_2x :
                        wave.dbl_1x;

  assign wave.clr      = loop_rst;
  assign wave.src_rise = src_rise;
  assign wave.period   = period_reg;
  assign wave.tap      = tap_reg;

  dlcp_wave_gen u_wave_gen (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wave      (wave)
  );

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg    <= ST_LOOP_RESET;
      src_q_reg    <= 1'b0;
      fb_q_reg     <= 1'b0;
      period_reg   <= CNT_ZERO;
      tap_reg      <= CNT_ZERO;
      lock_cnt_reg <= LOCK_ZERO;
      phase0_reg   <= 1'b0;
      doubled_reg  <= 1'b0;
      lock_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      src_q_reg    <= source_clock_in_i;
      fb_q_reg     <= fb_src;
      period_reg   <= period_next;
      tap_reg      <= tap_next;
      lock_cnt_reg <= lock_cnt_next;
      phase0_reg   <= phase0_next;
      doubled_reg  <= doubled_next;
      lock_reg     <= lock_next;
    end
  end

  // Feedback offset since the last source rise
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fb_off_reg  <= CNT_ZERO;
      fb_seen_reg <= 1'b0;
    end else if (fb_rise && !src_rise) begin
      fb_off_reg  <= wave.cnt + CNT_ONE;
      fb_seen_reg <= 1'b1;
    end else if (src_rise || loop_rst) begin
      fb_seen_reg <= 1'b0;
    end
  end

  assign phase0_clock_out_o  = phase0_reg;
  assign doubled_clock_out_o = doubled_reg;
  assign lock_o              = lock_reg;

  // ==========================================================================
  // Assertions
  property p_lock_drop;
    @(posedge ref_clk_i) disable iff (rst_i) loop_rst |=> !lock_o;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock still high after loop reset");

  property p_tap_zero;
    @(posedge ref_clk_i) disable iff (rst_i) loop_rst |=> (tap_reg == CNT_ZERO) && (period_reg == CNT_ZERO);
  endproperty
  a_tap_zero: assert property (p_tap_zero) else $error("taps not cleared by loop reset");

  property p_raw_in_reset;
    @(posedge ref_clk_i) disable iff (rst_i) loop_rst |=> phase0_clock_out_o == $past(source_clock_in_i);
  endproperty
  a_raw_in_reset: assert property (p_raw_in_reset) else $error("phase output not raw during reset");

  property p_dbl_unlocked;
    @(posedge ref_clk_i) disable iff (rst_i)
      (has_dbl && !is_simple && state_next == ST_ACQUIRE) |=> doubled_clock_out_o == $past(wave.dbl_1x);
  endproperty
  a_dbl_unlocked: assert property (p_dbl_unlocked) else $error("doubled output not quarter duty before lock");

  property p_dbl_locked;
    @(posedge ref_clk_i) disable iff (rst_i)
      (has_dbl && lock_next) |=> doubled_clock_out_o == $past(wave.dbl_2x);
  endproperty
  a_dbl_locked: assert property (p_dbl_locked) else $error("doubled output not doubled after lock");

  property p_no_dbl;
    @(posedge ref_clk_i) disable iff (rst_i) (!has_dbl || is_simple) |-> !doubled_clock_out_o;
  endproperty
  a_no_dbl: assert property (p_no_dbl) else $error("doubled output toggles in variant without it");

  property p_dcc_on;
    @(posedge ref_clk_i) disable iff (rst_i)
      (dcc_enable_i && !in_rst) |=> phase0_clock_out_o == $past(wave.ph0_corr);
  endproperty
  a_dcc_on: assert property (p_dcc_on) else $error("phase output not duty corrected");

  property p_simple_no_lock;
    @(posedge ref_clk_i) disable iff (rst_i) is_simple |-> !lock_o;
  endproperty
  a_simple_no_lock: assert property (p_simple_no_lock) else $error("simple macro shows lock");

  property p_lock_earned;
    @(posedge ref_clk_i) disable iff (rst_i) $rose(lock_o) |-> $past(lock_cnt_reg) >= LOCK_CYCLES;
  endproperty
  a_lock_earned: assert property (p_lock_earned) else $error("lock rose before enough aligned cycles");

  property p_dcc_off;
    @(posedge ref_clk_i) disable iff (rst_i)
      (!dcc_enable_i && !in_rst) |=> phase0_clock_out_o == $past(source_clock_in_i);
  endproperty
  a_dcc_off: assert property (p_dcc_off) else $error("phase output duty differs from source");

  property p_hold_low;
    @(posedge ref_clk_i) disable iff (rst_i) loop_rst ##1 loop_rst |-> !lock_o && (lock_cnt_reg == LOCK_ZERO);
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("lock progress during held loop reset");

endmodule

//--- rtl/dlcp_pkg.sv
// Shared constants, types and helpers of the clock deskew loop
package dlcp_pkg;

  // ==========================================================================
  // Widths and constants
  localparam int              CNT_W           = 8;
  localparam int              LOCK_W          = 16;
  localparam logic [7:0]      CNT_ZERO        = 8'h00;
  localparam logic [7:0]      CNT_ONE         = 8'h01;
  localparam logic [7:0]      CNT_MAX         = 8'hFF;
  localparam logic [15:0]     LOCK_ZERO       = 16'h0000;
  localparam logic [15:0]     LOCK_ONE        = 16'h0001;
  localparam logic [15:0]     LOCK_CYCLES_DEF = 16'h1000;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    DLCP_SIMPLE    = 2'b00,
    DLCP_FULL      = 2'b01,
    DLCP_HIGH_FREQ = 2'b10
  } dlcp_variant_t;

  typedef enum logic [1:0] {
    ST_LOOP_RESET = 2'b00,
    ST_ACQUIRE    = 2'b01,
    ST_LOCKED     = 2'b10
  } dlcp_state_t;

  // ==========================================================================
  // Modular add, operands below the modulus
  function automatic logic [CNT_W-1:0] dlcp_mod_add(input logic [CNT_W-1:0] a,
                                                     input logic [CNT_W-1:0] b,
                                                     input logic [CNT_W-1:0] m);
    logic [CNT_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if ((m != CNT_ZERO) && (s >= {1'b0, m})) begin
      s = s - {1'b0, m};
    end
    return s[CNT_W-1:0];
  endfunction

endpackage

//--- rtl/dlcp_wave_if.sv
// Signals between the loop controller and the waveform generator
`timescale 1ns/10ps
interface dlcp_wave_if;
  import dlcp_pkg::*;
  logic             clr;
  logic             src_rise;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] tap;
  logic [CNT_W-1:0] cnt;
  logic             ph0_corr;
  logic             dbl_1x;
  logic             dbl_2x;

  modport gen (input clr, input src_rise, input period, input tap,
               output cnt, output ph0_corr, output dbl_1x, output dbl_2x);
  modport ctl (output clr, output src_rise, output period, output tap,
               input cnt, input ph0_corr, input dbl_1x, input dbl_2x);
endinterface

//--- rtl/dlcp_wave_gen.sv
// Phase counter and output waveform shaping of the deskew loop
`timescale 1ns/10ps
module dlcp_wave_gen
  import dlcp_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  dlcp_wave_if.gen  wave
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  wire  [CNT_W-1:0] pos;
  wire  [CNT_W-1:0] half;
  wire  [CNT_W-1:0] qtr;
  wire  [CNT_W-1:0] three_qtr;

  // ==========================================================================
  // Cycles since the last source rise, restarted by it
  assign cnt_next = wave.clr      ? CNT_ZERO :
                    wave.src_rise ? CNT_ZERO :
                    (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + CNT_ONE;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_reg <= CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // ==========================================================================
  // Advanced position within the period and the shaped levels
  assign pos       = (cnt_reg < wave.period) ? dlcp_mod_add(cnt_reg, wave.tap, wave.period) : cnt_reg;
  assign half      = wave.period >> 1;
  assign qtr       = wave.period >> 2;
  assign three_qtr = half + qtr;

  assign wave.cnt      = cnt_reg;
  assign wave.ph0_corr = (pos < half);
  assign wave.dbl_1x   = (pos < qtr);
  assign wave.dbl_2x   = (pos < qtr) || ((pos >= half) && (pos < three_qtr));

endmodule

//--- bench/dlcp_src_model.sv
// Board clock source and feedback path model of the deskew loop
`timescale 1ns/10ps
module dlcp_src_model #(
  parameter int FB_DELAY = 3
)(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] period_i,
  input  wire logic [7:0] high_i,
  input  wire logic       phase0_i,
  output logic            source_clock_o,
  output logic            feedback_clock_o
);
  logic [7:0]          cnt_reg  = 8'h00;
  logic [FB_DELAY-1:0] fb_reg   = '0;

  // ==========================================================================
  // Source oscillator, changes only on the falling edge
  always @(negedge ref_clk_i) begin
    if (rst_i || (cnt_reg >= period_i - 8'h01)) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
    fb_reg <= {fb_reg[FB_DELAY-2:0], phase0_i};
  end

  // External port through a same-edge global input buffer
  assign source_clock_o   = (cnt_reg < high_i);
  // Only the phase-zero output returns, after board skew
  assign feedback_clock_o = fb_reg[FB_DELAY-1];
endmodule

//--- bench/tb.sv
// Self-checking testbench of the deskew loop
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  import dlcp_pkg::*;
  localparam logic [LOCK_W-1:0] LOCKN = 16'h0008;
  logic       ref_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic       loop_rst  = 1'b0;
  logic       dcc       = 1'b1;
  logic [7:0] period    = 8'h10;
  logic [7:0] high      = 8'h08;
  logic       src, fb, ph0, dbl, lock, ph0_h, dbl_h, lock_h, ph0_s, dbl_s, lock_s;
  int         n_mismatch = 0;
  int         checked    = 0;
  int         hi0, hi2, rise2, his, hih, bad_hf;

  always #10 ref_clk_i = ~ref_clk_i;

  dlcp_src_model model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .period_i(period), .high_i(high),
                        .phase0_i(ph0), .source_clock_o(src), .feedback_clock_o(fb));
  dlcp_deskew_loop #(.VARIANT(DLCP_FULL), .LOCK_CYCLES(LOCKN)) dut (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .source_clock_in_i(src), .feedback_clock_in_i(fb), .loop_rst_i(loop_rst),
    .dcc_enable_i(dcc), .phase0_clock_out_o(ph0), .doubled_clock_out_o(dbl), .lock_o(lock));
  dlcp_deskew_loop #(.VARIANT(DLCP_HIGH_FREQ), .LOCK_CYCLES(LOCKN)) dut_hf (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .source_clock_in_i(src), .feedback_clock_in_i(src), .loop_rst_i(loop_rst),
    .dcc_enable_i(dcc), .phase0_clock_out_o(ph0_h), .doubled_clock_out_o(dbl_h), .lock_o(lock_h));
  dlcp_deskew_loop #(.VARIANT(DLCP_SIMPLE), .LOCK_CYCLES(LOCKN)) dut_smp (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .source_clock_in_i(src), .feedback_clock_in_i(fb), .loop_rst_i(loop_rst),
    .dcc_enable_i(dcc), .phase0_clock_out_o(ph0_s), .doubled_clock_out_o(dbl_s), .lock_o(lock_s));

  // ==========================================================================
  // Shared helpers
  task automatic measure(input int n);
    logic prev;
    prev = dbl;
    hi0   = 0;
    hi2   = 0;
    rise2 = 0;
    his   = 0;
    hih   = 0;
    repeat (n) begin
      @(negedge ref_clk_i);
      if (ph0 === 1'b1) hi0++;
      if (dbl === 1'b1) hi2++;
      if (ph0_s === 1'b1) his++;
      if (ph0_h === 1'b1) hih++;
      if ((dbl === 1'b1) && (prev === 1'b0)) rise2++;
      if ((dbl_h !== 1'b0) || (dbl_s !== 1'b0) || (lock_s !== 1'b0)) bad_hf++;
      prev = dbl;
    end
  endtask

  task automatic wait_lock();
    int   k;
    int   rises;
    logic prev;
    rises = 0;
    prev  = src;
    for (k = 0; (k < 20000) && (lock !== 1'b1); k++) begin
      @(negedge ref_clk_i);
      if ((src === 1'b1) && (prev === 1'b0)) rises++;
      prev = src;
    end
    `CHK(lock, 1'b1)
    `CHK(rises >= int'(LOCKN), 1'b1)
  endtask

  task automatic conclude();
    $display("counts: checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if ((n_mismatch == 0) && (checked > 0)) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    repeat (4) begin
      @(negedge ref_clk_i);
      `CHK({ph0, dbl, lock}, 3'b000)
    end
    // Source model samples on this same edge, so release without a race
    rst_i <= 1'b0;
    $display("test reset done");
  endtask

  task automatic t_unlocked();
    repeat (64) @(negedge ref_clk_i);
    measure(16);
    `CHK(lock, 1'b0)
    `CHK((hi2 >= 3) && (hi2 <= 5), 1'b1)
    `CHK(rise2 <= 1, 1'b1)
    $display("test unlocked done");
  endtask

  task automatic t_locked(input int p);
    wait_lock();
    repeat (2 * p) @(negedge ref_clk_i);
    bad_hf = 0;
    measure(p);
    `CHK(hi2, p / 2)
    `CHK(rise2, 2)
    `CHK(hi0, p / 2)
    `CHK((his >= p / 2 - 1) && (his <= p / 2 + 1), 1'b1)
    `CHK(bad_hf, 0)
    `CHK(lock_h, 1'b1)
    `CHK(hih, p / 2)
    $display("test locked done");
  endtask

  task automatic t_loop_reset();
    int k;
    loop_rst = 1'b1;
    for (k = 0; (k < 4 * 16) && (lock !== 1'b0); k++) @(negedge ref_clk_i);
    `CHK(lock, 1'b0)
    repeat (16) @(negedge ref_clk_i);
    bad_hf = 0;
    measure(96);
    `CHK(lock, 1'b0)
    `CHK(hi2, 0)
    `CHK(hi0, 48)
    `CHK(bad_hf, 0)
    loop_rst = 1'b0;
    t_locked(16);
    $display("test loop reset done");
  endtask

  task automatic t_freq_change();
    loop_rst = 1'b1;
    period   <= 8'h14;
    high     = 8'h0A;
    repeat (40) @(negedge ref_clk_i);
    loop_rst = 1'b0;
    t_locked(20);
    $display("test frequency change done");
  endtask

  task automatic t_dcc_off();
    high = 8'h05;
    dcc  = 1'b0;
    repeat (60) @(negedge ref_clk_i);
    measure(20);
    `CHK(hi0, 5)
    `CHK(his, 5)
    $display("test duty correction off done");
  endtask

  initial begin
    t_reset();
    t_unlocked();
    t_locked(16);
    t_loop_reset();
    t_freq_change();
    t_dcc_off();
    conclude();
  end

  // Whole sequence needs somewhat over a thousand cycles
  initial begin
    #(20 * 60000);
    n_mismatch++;
    conclude();
  end
endmodule
